// ---- lsd_pkg.sv ----
// Constants, register indices and types for the sync lag and line pulse block.
// Assumes an APB master with 32-bit data; registers sit on aligned words.
package lsd_pkg;
    localparam int unsigned LSD_ADDR_W = 12;
    localparam int unsigned LSD_LAG_W = 12;
    localparam int unsigned LSD_LAG_HI_W = 4;
    localparam int unsigned LSD_HPW_W = 10;
    localparam int unsigned LSD_HPW_HI_W = 2;
    localparam int unsigned LSD_BYTE_W = 8;
    localparam int unsigned LSD_TIME_W = 13;
    localparam int unsigned LSD_LAT_PIX = 10;
    localparam int unsigned LSD_LAG_MIN_PIX = 32;
    localparam int unsigned LSD_DIV_W = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0] LSD_IDX_CHAN_MODE = 8'h10;
    localparam logic [7:0] LSD_IDX_LINK_SEL = 8'h18;
    localparam logic [7:0] LSD_IDX_LAG_LO = 8'h2A;
    localparam logic [7:0] LSD_IDX_LAG_HI = 8'h2B;
    localparam logic [7:0] LSD_IDX_HPW_LO = 8'h2C;
    localparam logic [7:0] LSD_IDX_HPW_HI = 8'h2D;
    localparam logic [7:0] LSD_IDX_STATUS = 8'h3F;
    // Field positions
    localparam int unsigned LSD_LINK_SEL_BIT = 4;
    localparam int unsigned LSD_CHMODE_LSB = 5;
    localparam int unsigned LSD_CHMODE_W = 2;
    localparam logic [1:0] LSD_CHMODE_TWO_STREAM = 2'h2;
    localparam logic [1:0] LSD_CHMODE_ODD_EVEN = 2'h0;
    localparam logic [1:0] LSD_CHMODE_LEFT_RIGHT = 2'h1;
    localparam int unsigned LSD_ST_TWO_STREAM = 0;
    localparam int unsigned LSD_ST_LAG_LOW = 1;
    localparam int unsigned LSD_ST_PULSE = 2;
    localparam int unsigned LSD_ST_DROP = 3;
    localparam int unsigned LSD_ST_BUSY = 4;
    // Reset values
    localparam logic [7:0] LSD_RST_BYTE = 8'h00;
    localparam logic [31:0] LSD_RD_ZERO = 32'h0000_0000;

    typedef enum logic {
        LSD_P_IDLE = 1'b0,
        LSD_P_HIGH = 1'b1
    } lsd_pulse_state_type;

    function automatic logic lsd_hit(input logic [LSD_ADDR_W-1:0] addr, input logic [7:0] idx);
        lsd_hit = (addr == {2'h0, idx, 2'h0});
    endfunction : lsd_hit
endpackage : lsd_pkg

// ---- lsd_lag_if.sv ----
// Carrier between the block top and its sync lag queue.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface lsd_lag_if;
    import lsd_pkg::*;
    logic pix_en;
    logic [LSD_LAG_W-1:0] lag;
    logic hs_evt;
    logic vs_evt;
    logic hs_out;
    logic vs_out;
    logic drop;
    logic busy;
    modport ctl (output pix_en, lag, hs_evt, vs_evt, input hs_out, vs_out, drop, busy);
    modport lag_end (input pix_en, lag, hs_evt, vs_evt, output hs_out, vs_out, drop, busy);
endinterface : lsd_lag_if

// ---- lsd_sync_lag.sv ----
// Time-stamp queue that delays sync events for the second output channel.
// Assumes events and the pixel enable arrive on the block clock.
`timescale 1ns/1ps
module lsd_sync_lag
    import lsd_pkg::*;
#(
    parameter int unsigned DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    lsd_lag_if.lag_end lag_if
);
    localparam logic [LSD_TIME_W-1:0] LAT_TIME = LSD_TIME_W'(LSD_LAT_PIX);
    localparam int unsigned IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [LSD_TIME_W-1:0] now;
    logic [DEPTH-1:0] slot_valid;
    logic [LSD_TIME_W-1:0] slot_due [DEPTH];
    logic [DEPTH-1:0] slot_hs;
    logic [DEPTH-1:0] slot_vs;
    logic [DEPTH-1:0] slot_hit;
    logic [IDX_W-1:0] free_idx;
    logic have_free;
    logic drop;
    wire push = lag_if.pix_en && (lag_if.hs_evt || lag_if.vs_evt);
    // Stamp is fixed at arrival, so a lag change never retimes events already in flight
    wire [LSD_TIME_W-1:0] due_new = now + {1'b0, lag_if.lag} + LAT_TIME;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_hit
            assign slot_hit[g] = slot_valid[g] && (slot_due[g] == now);
        end
    endgenerate

    always_comb begin
        free_idx = '0;
        have_free = 1'b0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (!slot_valid[i]) begin
                free_idx = IDX_W'(i);
                have_free = 1'b1;
            end
        end
    end

    assign lag_if.hs_out = |(slot_hit & slot_hs);
    assign lag_if.vs_out = |(slot_hit & slot_vs);
    assign lag_if.drop = drop;
    assign lag_if.busy = |slot_valid;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            now <= '0;
            slot_valid <= '0;
            slot_hs <= '0;
            slot_vs <= '0;
            drop <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                slot_due[i] <= '0;
            end
        end else begin
            drop <= push && !have_free;
            if (lag_if.pix_en) begin
                now <= now + 1'b1;
                slot_valid <= slot_valid & ~slot_hit;
                if (push && have_free) begin
                    slot_valid[free_idx] <= 1'b1;
                    slot_due[free_idx] <= due_new;
                    slot_hs[free_idx] <= lag_if.hs_evt;
                    slot_vs[free_idx] <= lag_if.vs_evt;
                end
            end
        end
    end
endmodule : lsd_sync_lag

// ---- lsd_top.sv ----
// Sync lag for output channel B and line pulse width for output channel A.
// Assumes DSI sync strobes come from decoder logic on i_clk; APB slave registers.
// Operation
// - Channel B sync events leave after the programmed lag in pixel clocks.
// - The lag applies only with dual selector 0 and channel field 10.
// - The lag adds to the fixed pipeline latency, not replacing it.
// - The fixed pipeline latency is ten pixel clocks.
// - The lag is twelve bits; low eight bits sit at index 0x2A.
// - Upper four lag bits sit in bits 3 to 0 at 0x2B.
// - Channel A line pulse lasts the programmed width in pixel clocks.
// - Width drives A in single mode, both channels in dual 00 or 01.
// - The width is ten bits; low eight bits sit at index 0x2C.
// - Upper two width bits sit at index 0x2D; bits 7 to 2 reserved.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module lsd_top
    import lsd_pkg::*;
#(
    parameter int unsigned PIX_DIV = 2,
    parameter int unsigned LAG_DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [LSD_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_dsi_hsync,
    input wire logic i_dsi_vsync,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_cha_hsync,
    output logic o_cha_vsync,
    output logic o_chb_hsync,
    output logic o_chb_vsync
);
    localparam logic [LSD_DIV_W-1:0] DIV_LAST = LSD_DIV_W'(PIX_DIV - 1);
    localparam logic [LSD_LAG_W-1:0] LAG_MIN = LSD_LAG_W'(LSD_LAG_MIN_PIX);

    lsd_lag_if lag_if ();

    // Pixel clock enable
    logic [LSD_DIV_W-1:0] pix_cnt;
    logic pix_en;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pix_cnt <= '0;
            pix_en <= 1'b0;
        end else begin
            pix_en <= (pix_cnt == DIV_LAST);
            if (pix_cnt == DIV_LAST) begin
                pix_cnt <= '0;
            end else begin
                pix_cnt <= pix_cnt + 1'b1;
            end
        end
    end

    // Configuration registers
    logic [LSD_BYTE_W-1:0] lag_lo;
    logic [LSD_LAG_HI_W-1:0] lag_hi;
    logic [LSD_BYTE_W-1:0] hpw_lo;
    logic [LSD_HPW_HI_W-1:0] hpw_hi;
    logic [LSD_CHMODE_W-1:0] chan_mode;
    logic link_sel;
    logic drop_seen;

    // APB decode
    wire access = i_psel && i_penable;
    wire wr_fire = access && o_pready && i_pwrite;
    wire lane0 = i_pstrb[0];
    wire hit_chmode = lsd_hit(i_paddr, LSD_IDX_CHAN_MODE);
    wire hit_link = lsd_hit(i_paddr, LSD_IDX_LINK_SEL);
    wire hit_lag_lo = lsd_hit(i_paddr, LSD_IDX_LAG_LO);
    wire hit_lag_hi = lsd_hit(i_paddr, LSD_IDX_LAG_HI);
    wire hit_hpw_lo = lsd_hit(i_paddr, LSD_IDX_HPW_LO);
    wire hit_hpw_hi = lsd_hit(i_paddr, LSD_IDX_HPW_HI);
    wire hit_status = lsd_hit(i_paddr, LSD_IDX_STATUS);
    wire hit_any = hit_chmode || hit_link || hit_lag_lo || hit_lag_hi ||
                   hit_hpw_lo || hit_hpw_hi || hit_status;

    // Modes
    wire two_stream = !link_sel && (chan_mode == LSD_CHMODE_TWO_STREAM);
    wire shared = !link_sel && ((chan_mode == LSD_CHMODE_ODD_EVEN) ||
                                (chan_mode == LSD_CHMODE_LEFT_RIGHT));
    wire [LSD_LAG_W-1:0] lag_full = {lag_hi, lag_lo};
    wire [LSD_HPW_W-1:0] hpw_full = {hpw_hi, hpw_lo};
    // Below-minimum lag is not blocked, only flagged; timing is then unspecified
    wire lag_low = two_stream && (lag_full < LAG_MIN);

    logic pulse_busy;
    logic [31:0] rd_data;

    always_comb begin
        rd_data = LSD_RD_ZERO;
        if (hit_chmode) begin
            rd_data[LSD_CHMODE_LSB +: LSD_CHMODE_W] = chan_mode;
        end else if (hit_link) begin
            rd_data[LSD_LINK_SEL_BIT] = link_sel;
        end else if (hit_lag_lo) begin
            rd_data[LSD_BYTE_W-1:0] = lag_lo;
        end else if (hit_lag_hi) begin
            rd_data[LSD_LAG_HI_W-1:0] = lag_hi;
        end else if (hit_hpw_lo) begin
            rd_data[LSD_BYTE_W-1:0] = hpw_lo;
        end else if (hit_hpw_hi) begin
            rd_data[LSD_HPW_HI_W-1:0] = hpw_hi;
        end else if (hit_status) begin
            rd_data[LSD_ST_TWO_STREAM] = two_stream;
            rd_data[LSD_ST_LAG_LOW] = lag_low;
            rd_data[LSD_ST_PULSE] = pulse_busy;
            rd_data[LSD_ST_DROP] = drop_seen;
            rd_data[LSD_ST_BUSY] = lag_if.busy;
        end
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= LSD_RD_ZERO;
        end else begin
            o_pready <= access && !o_pready;
            o_pslverr <= access && !o_pready && !hit_any;
            if (access && !o_pready && !i_pwrite) begin
                o_prdata <= rd_data;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lag_lo <= LSD_RST_BYTE;
            lag_hi <= LSD_RST_BYTE[LSD_LAG_HI_W-1:0];
            hpw_lo <= LSD_RST_BYTE;
            hpw_hi <= LSD_RST_BYTE[LSD_HPW_HI_W-1:0];
            chan_mode <= LSD_RST_BYTE[LSD_CHMODE_W-1:0];
            link_sel <= 1'b0;
        end else if (wr_fire && lane0) begin
            if (hit_chmode) begin
                chan_mode <= i_pwdata[LSD_CHMODE_LSB +: LSD_CHMODE_W];
            end else if (hit_link) begin
                link_sel <= i_pwdata[LSD_LINK_SEL_BIT];
            end else if (hit_lag_lo) begin
                lag_lo <= i_pwdata[LSD_BYTE_W-1:0];
            end else if (hit_lag_hi) begin
                lag_hi <= i_pwdata[LSD_LAG_HI_W-1:0];
            end else if (hit_hpw_lo) begin
                hpw_lo <= i_pwdata[LSD_BYTE_W-1:0];
            end else if (hit_hpw_hi) begin
                hpw_hi <= i_pwdata[LSD_HPW_HI_W-1:0];
            end
        end
    end

    // Overflow flag: write 1 clears, a new drop in the same cycle wins
    wire drop_clr = wr_fire && lane0 && hit_status && i_pwdata[LSD_ST_DROP];
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drop_seen <= 1'b0;
        end else if (lag_if.drop) begin
            drop_seen <= 1'b1;
        end else if (drop_clr) begin
            drop_seen <= 1'b0;
        end
    end

    // Strobes are shorter than a pixel period, so hold them until the next tick
    logic hs_pend;
    logic vs_pend;
    wire hs_evt = hs_pend || i_dsi_hsync;
    wire vs_evt = vs_pend || i_dsi_vsync;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hs_pend <= 1'b0;
            vs_pend <= 1'b0;
        end else if (pix_en) begin
            hs_pend <= 1'b0;
            vs_pend <= 1'b0;
        end else begin
            hs_pend <= hs_evt;
            vs_pend <= vs_evt;
        end
    end

    // Fixed pipeline latency for channel A
    logic [LSD_LAT_PIX-1:0] a_hs_pipe;
    logic [LSD_LAT_PIX-1:0] a_vs_pipe;
    wire a_hs_evt = a_hs_pipe[LSD_LAT_PIX-1];
    wire a_vs_evt = a_vs_pipe[LSD_LAT_PIX-1];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_hs_pipe <= '0;
            a_vs_pipe <= '0;
        end else if (pix_en) begin
            a_hs_pipe <= {a_hs_pipe[LSD_LAT_PIX-2:0], hs_evt};
            a_vs_pipe <= {a_vs_pipe[LSD_LAT_PIX-2:0], vs_evt};
        end
    end

    // Line pulse generator; a new event restarts the count
    lsd_pulse_state_type state;
    lsd_pulse_state_type next_state;
    logic [LSD_HPW_W-1:0] remain;
    logic [LSD_HPW_W-1:0] next_remain;
    wire width_zero = (hpw_full == '0);

    always_comb begin
        next_state = state;
        next_remain = remain;
        case (state)
            LSD_P_IDLE: begin
                if (pix_en && a_hs_evt && !width_zero) begin
                    next_state = LSD_P_HIGH;
                    next_remain = hpw_full;
                end
            end
            LSD_P_HIGH: begin
                if (pix_en && a_hs_evt && !width_zero) begin
                    next_remain = hpw_full;
                end else if (pix_en && a_hs_evt) begin
                    next_state = LSD_P_IDLE;
                end else if (pix_en && (remain <= 1)) begin
                    next_state = LSD_P_IDLE;
                end else if (pix_en) begin
                    next_remain = remain - 1'b1;
                end
            end
            default: begin
                next_state = LSD_P_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= LSD_P_IDLE;
            remain <= '0;
            pulse_busy <= 1'b0;
        end else begin
            state <= next_state;
            remain <= next_remain;
            pulse_busy <= (next_state == LSD_P_HIGH);
        end
    end

    // Lag queue for channel B; outside two-stream mode only the fixed latency remains
    assign lag_if.pix_en = pix_en;
    assign lag_if.lag = two_stream ? lag_full : '0;
    assign lag_if.hs_evt = hs_evt;
    assign lag_if.vs_evt = vs_evt;

    lsd_sync_lag #(
        .DEPTH(LAG_DEPTH)
    ) u_lag (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .lag_if(lag_if.lag_end)
    );

    // Output channels, updated once per pixel period except the width pulse and the cleared channel B outputs
    wire a_active = link_sel || shared || two_stream;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cha_hsync <= 1'b0;
            o_cha_vsync <= 1'b0;
            o_chb_hsync <= 1'b0;
            o_chb_vsync <= 1'b0;
        end else begin
            o_cha_hsync <= (next_state == LSD_P_HIGH) && a_active;
            if (pix_en) begin
                o_cha_vsync <= a_vs_evt && a_active;
            end
            if (two_stream) begin
                if (pix_en) begin
                    o_chb_hsync <= lag_if.hs_out;
                    o_chb_vsync <= lag_if.vs_out;
                end
            end else if (shared) begin
                o_chb_hsync <= (next_state == LSD_P_HIGH);
                if (pix_en) begin
                    o_chb_vsync <= a_vs_evt;
                end
            end else begin
                o_chb_hsync <= 1'b0;
                o_chb_vsync <= 1'b0;
            end
        end
    end
endmodule : lsd_top

// ---- lsd_top_asserts.sv ----
// Port-level checks for lsd_top, with shadows of the mode and width registers.
// Assumes it is bound into lsd_top and sees every APB write at the ports.
`timescale 1ns/1ps
module lsd_top_asserts
    import lsd_pkg::*;
#(
    parameter int unsigned PIX_DIV = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [LSD_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_dsi_hsync,
    input wire logic i_dsi_vsync,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_cha_hsync,
    input wire logic o_cha_vsync,
    input wire logic o_chb_hsync,
    input wire logic o_chb_vsync
);
    logic [LSD_HPW_W-1:0] hpw;
    logic single;
    logic [1:0] chmode;
    logic [11:0] hs_cnt;
    wire logic [9:0] idx = i_paddr[11:2];
    wire logic done = o_pready && i_psel && i_penable && (i_paddr[1:0] == 2'h0);
    wire logic wr = done && i_pwrite && i_pstrb[0];
    wire logic rd = done && !i_pwrite;
    wire logic mapped = (i_paddr[1:0] == 2'h0) && (idx == 10'h010 || idx == 10'h018
        || (idx >= 10'h02A && idx <= 10'h02D) || idx == 10'h03F);
    // Mode 11 on a dual link silences all outputs, so no pulse is due there
    wire logic pulse_on = (hpw != 10'h000) && (single || chmode != 2'h3);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hpw <= '0;
            single <= 1'b0;
            chmode <= 2'h0;
            hs_cnt <= 12'h000;
        end else begin
            if (wr && idx == 10'h02C) hpw[7:0] <= i_pwdata[7:0];
            if (wr && idx == 10'h02D) hpw[9:8] <= i_pwdata[1:0];
            if (wr && idx == 10'h018) single <= i_pwdata[4];
            if (wr && idx == 10'h010) chmode <= i_pwdata[6:5];
            hs_cnt <= o_cha_hsync ? hs_cnt + 12'h001 : 12'h000;
        end
    end
    a_ready_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_penable) && i_psel |-> !o_pready ##1 o_pready) else $error("ready late");
    a_ready_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pready |=> !o_pready) else $error("ready longer than one cycle");
    a_slave_err: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pready && i_psel && i_penable |-> o_pslverr == !mapped) else $error("bad error flag");
    a_lag_hi_resv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd && idx == 10'h02B |-> o_prdata[31:4] == 28'h0) else $error("lag reserved bits set");
    a_hpw_lo_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd && idx == 10'h02C |-> o_prdata == {24'h0, hpw[7:0]}) else $error("width low read");
    a_hpw_hi_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd && idx == 10'h02D |-> o_prdata == {30'h0, hpw[9:8]}) else $error("width high read");
    a_hs_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_cha_hsync) |-> hs_cnt == 12'(hpw) * 12'(PIX_DIV)) else $error("line pulse width");
    a_hs_latency: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_dsi_hsync) && pulse_on |-> ##[19:23] o_cha_hsync) else $error("line pulse late");
    a_a_vs_lat: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_dsi_vsync) && (single || chmode != 2'h3) |-> ##[19:23] o_cha_vsync)
        else $error("A vsync late");
    a_b_vs_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_chb_vsync) |=> o_chb_vsync ##1 !o_chb_vsync) else $error("B vsync length");
endmodule : lsd_top_asserts

bind lsd_top lsd_top_asserts #(.PIX_DIV(PIX_DIV)) u_asserts (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .i_dsi_hsync(i_dsi_hsync), .i_dsi_vsync(i_dsi_vsync), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_cha_hsync(o_cha_hsync),
    .o_cha_vsync(o_cha_vsync), .o_chb_hsync(o_chb_hsync), .o_chb_vsync(o_chb_vsync)
);

// ---- lsd_panel_model.sv ----
// Panel stand-in on both output channels: logs channel A hsync and channel B hsync and vsync rise times and the channel A line pulse width.
// Assumes the block clock; all times are counts of that clock.
`timescale 1ns/1ps
module lsd_panel_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_a_hs,
    input wire logic i_b_hs,
    input wire logic i_b_vs,
    output logic [31:0] o_now,
    output logic [31:0] o_a_rise,
    output logic [31:0] o_bh_rise,
    output logic [31:0] o_bv_rise,
    output logic [15:0] o_a_len
);
    logic [15:0] a_cnt;
    logic a_q, bh_q, bv_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {o_now, o_a_rise, o_bh_rise, o_bv_rise, o_a_len, a_cnt} <= '0;
            {a_q, bh_q, bv_q} <= 3'h0;
        end else begin
            o_now <= o_now + 32'h1;
            {a_q, bh_q, bv_q} <= {i_a_hs, i_b_hs, i_b_vs};
            a_cnt <= i_a_hs ? a_cnt + 16'h1 : 16'h0;
            if (i_a_hs && !a_q) o_a_rise <= o_now;
            if (i_b_hs && !bh_q) o_bh_rise <= o_now;
            if (i_b_vs && !bv_q) o_bv_rise <= o_now;
            // Width is taken only at the falling edge, so a stuck line never reports
            if (!i_a_hs && a_q) o_a_len <= a_cnt;
        end
    end
endmodule : lsd_panel_model

// ---- tb.sv ----
// Self-checking bench for lsd_top: register access over APB and sync timing.
// Assumes lsd_top, its checker and the panel model are compiled before it.
`timescale 1ns/1ps
module tb;
    import lsd_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [LSD_ADDR_W-1:0] i_paddr = '0;
    logic [31:0] i_pwdata = 32'h0;
    logic [3:0] i_pstrb = 4'h0;
    logic i_dsi_hsync = 1'b0;
    logic i_dsi_vsync = 1'b0;
    logic [31:0] o_prdata, now, a_rise, bh_rise, bv_rise, t0, rd;
    logic o_pready, o_pslverr, o_cha_hsync, o_cha_vsync, o_chb_hsync, o_chb_vsync, err;
    logic [15:0] a_len;
    int errors = 0;
    int comparisons = 0;
    integer seed = 32'hB3FCB413;
    logic [7:0] idx_t [4] = '{LSD_IDX_LAG_LO, LSD_IDX_LAG_HI, LSD_IDX_HPW_LO, LSD_IDX_HPW_HI};
    logic [31:0] msk_t [4] = '{32'h0000_00FF, 32'h0000_000F, 32'h0000_00FF, 32'h0000_0003};
    always #2 i_clk = ~i_clk;
    lsd_top #(.PIX_DIV(2), .LAG_DEPTH(4)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .i_dsi_hsync(i_dsi_hsync),
        .i_dsi_vsync(i_dsi_vsync), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_cha_hsync(o_cha_hsync), .o_cha_vsync(o_cha_vsync),
        .o_chb_hsync(o_chb_hsync), .o_chb_vsync(o_chb_vsync));
    lsd_panel_model panel (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_a_hs(o_cha_hsync),
        .i_b_hs(o_chb_hsync), .i_b_vs(o_chb_vsync), .o_now(now), .o_a_rise(a_rise),
        .o_bh_rise(bh_rise), .o_bv_rise(bv_rise), .o_a_len(a_len));
    function automatic logic [31:0] exp_rd(input int i, input logic [31:0] v);
        return v & msk_t[i];
    endfunction : exp_rd
    function automatic logic lat_ok(input logic [31:0] rise, input int lag);
        int d;
        d = int'(rise - t0);
        return d >= 2 * (lag + LSD_LAT_PIX) && d <= 2 * (lag + LSD_LAT_PIX) + 3;
    endfunction : lat_ok
    task automatic stop_test();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    // Ready, data and error are taken at the rising edge that completes the access
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       input logic [3:0] st);
        int n;
        @(posedge i_clk);
        {i_psel, i_penable, i_pwrite, i_pwdata, i_pstrb} <= {2'b10, w, d, st};
        i_paddr <= {2'h0, idx, 2'h0};
        @(posedge i_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (o_pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            stop_test();
        end
        {rd, err} = {o_prdata, o_pslverr};
        {i_psel, i_penable} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 4'hF);
    endtask : wr
    task automatic ev(input logic hs, input logic vs, input int wait_clk);
        @(posedge i_clk);
        {i_dsi_hsync, i_dsi_vsync} <= {hs, vs};
        @(negedge i_clk);
        t0 = now;
        @(posedge i_clk);
        {i_dsi_hsync, i_dsi_vsync} <= 2'b00;
        repeat (wait_clk) @(posedge i_clk);
        @(negedge i_clk);
    endtask : ev
    initial begin
        repeat (100000) @(posedge i_clk);
        errors++;
        stop_test();
    end
    initial begin
        int i, k, m, w, lag;
        logic [31:0] v, b0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, idx_t[i], 32'h0, 4'h0);
            check(rd, 32'h0, "reset value");
        end
        for (k = 0; k < 3; k++) begin
            v = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
            for (i = 0; i < 4; i++) begin
                wr(idx_t[i], v);
                apb(1'b0, idx_t[i], 32'h0, 4'h0);
                check(rd, exp_rd(i, v), "readback");
            end
        end
        apb(1'b0, 8'h2E, 32'h0, 4'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        // Lag stays non-zero here, so a copied B channel proves the lag is unused
        for (m = 0; m < 3; m++) begin
            wr(LSD_IDX_LINK_SEL, (m == 0) ? 32'h10 : 32'h0);
            wr(LSD_IDX_CHAN_MODE, (m == 2) ? 32'h20 : 32'h0);
            w = (m == 1) ? 257 : 1 + ($unsigned($random(seed)) % 16);
            wr(LSD_IDX_HPW_LO, w & 32'hFF);
            wr(LSD_IDX_HPW_HI, (w >> 8) | 32'hFC);
            b0 = bh_rise;
            ev(1'b1, 1'b0, 2 * (w + LSD_LAT_PIX) + 16);
            check(32'(lat_ok(a_rise, 0)), 32'h1, "A latency");
            check(32'(a_len), 32'(2 * w), "A width");
            check(bh_rise, (m == 0) ? b0 : a_rise, "B follows A");
        end
        wr(LSD_IDX_LINK_SEL, 32'h0);
        wr(LSD_IDX_CHAN_MODE, 32'h40);
        for (k = 0; k < 3; k++) begin
            // Software never programs below the minimum lag
            lag = (k == 0) ? 32 : (k == 1) ? 261 : 32 + ($unsigned($random(seed)) % 64);
            wr(LSD_IDX_LAG_LO, lag & 32'hFF);
            wr(LSD_IDX_LAG_HI, (lag >> 8) | ($random(seed) & 32'hF0));
            ev(1'b1, 1'b1, 2 * (lag + LSD_LAT_PIX) + 16);
            check(32'(lat_ok(bv_rise, lag)), 32'h1, "B vsync lag");
            check(32'(lat_ok(bh_rise, lag)), 32'h1, "B hsync lag");
            check(32'(lat_ok(a_rise, 0)), 32'h1, "A no lag");
        end
        apb(1'b0, LSD_IDX_STATUS, 32'h0, 4'h0);
        check(rd, 32'h1 << LSD_ST_TWO_STREAM, "two-stream status");
        stop_test();
    end
endmodule : tb
